/* File: logic/mxd_pkg.sv */
package mxd_pkg;
	localparam int NUM_M = 9;
	localparam int NUM_S = 8;
	localparam int CPU_I = 0;
	localparam int CPU_D = 1;
	localparam int BANK_HI = 31;
	localparam int BANK_LO = 28;
	localparam int RGN_HI = 27;
	localparam int RGN_LO = 20;
	localparam int BLK_HI = 19;
	localparam int BLK_LO = 14;
	localparam logic [3:0] BANK_INT = 4'h0;
	localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
	localparam logic [3:0] BANK_EXT_LAST = 4'h9;
	localparam logic [3:0] BANK_PERIPH = 4'hf;
	localparam logic [3:0] EXT0_CS_CNT = 4'h6;
	localparam logic [7:0] RGN_BOOT = 8'h00;
	localparam logic [7:0] RGN_INSTR_TIGHT_SRAM = 8'h01;
	localparam logic [7:0] RGN_DATA_TIGHT_SRAM = 8'h02;
	localparam logic [7:0] RGN_SRAMC = 8'h03;
	localparam logic [7:0] RGN_ROM = 8'h04;
	localparam logic [7:0] RGN_SRAM16 = 8'h05;
	localparam logic [5:0] ROM_BLKS = 6'h08;
	localparam logic [5:0] SRAM16_BLKS = 6'h01;
	localparam logic [2:0] NUM_RB = 3'h5;
	localparam logic [2:0] RB0 = 3'h0;
	localparam logic [2:0] RB1 = 3'h1;
	localparam logic [2:0] RB2 = 3'h2;
	localparam logic [2:0] RB3 = 3'h3;
	localparam logic [2:0] RB4 = 3'h4;
	localparam logic [1:0] TCM_MAX = 2'h2;
	localparam logic VSEL_3V3 = 1'b0;
	localparam logic BOOT_RST = 1'b1;
	typedef enum logic [3:0] {
		SL_NONE = 4'h0, SL_ROM = 4'h1, SL_INSTR_TIGHT_SRAM = 4'h2, SL_DATA_TIGHT_SRAM = 4'h3,
		SL_SRAMC = 4'h4, SL_SRAM16 = 4'h5, SL_EXT0 = 4'h6, SL_EXT1 = 4'h7,
		SL_PERIPH = 4'h8
	} mxd_slave_t;
	typedef enum logic [1:0] {
		ARB_FIXED = 2'h0, ARB_RR_NONE = 2'h1, ARB_RR_LAST = 2'h2,
		ARB_RR_FIXDEF = 2'h3
	} mxd_arb_t;
	typedef struct packed {
		logic vld;
		logic [31:0] addr;
	} mxd_req_t;
	typedef struct packed {
		logic done;
		logic err;
		mxd_slave_t slave;
		logic [3:0] cs;
		logic [2:0] blk;
	} mxd_rsp_t;
	typedef struct packed {
		mxd_arb_t mode;
		logic [3:0] def_m;
		logic [7:0] slot_lim;
	} mxd_cfg_t;
endpackage

/* File: logic/mxd_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module mxd_decode import mxd_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic boot_select_pin_i,
	input wire logic remap_cmd_i,
	input wire logic tcm_cfg_wr_i,
	input wire logic [1:0] instr_tight_sram_size_i,
	input wire logic [1:0] data_tight_sram_size_i,
	input wire logic vsel_wr_i,
	input wire logic vsel_i,
	input wire mxd_cfg_t arb_cfg_i,
	input wire mxd_req_t [NUM_M-1:0] req_i,
	input wire logic [NUM_S-1:0] slv_ready_i,
	output logic [NUM_M-1:0] gnt_o,
	output mxd_rsp_t [NUM_M-1:0] rsp_o,
	output logic remap_o,
	output logic boot_mode_o,
	output logic [1:0] instr_tight_sram_size_o,
	output logic [1:0] data_tight_sram_size_o,
	output logic [4:0] rb_on_tcm_o,
	output logic ext_if0_vsel_o
);
	logic [2:0] bsync_q, bfill_q;
	logic boot_q, boot_taken_q, remap_q, vsel_q;
	logic [1:0] isz_q, dsz_q;
	mxd_rsp_t [NUM_M-1:0] dec, rsp_q;
	logic [NUM_S-1:0][NUM_M-1:0] gs;

	// ==========================================================
	// Boot strap and remap state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bsync_q <= 3'h0;
			bfill_q <= 3'h0;
		end else if (clk_en_i) begin
			bsync_q <= {bsync_q[1:0], boot_select_pin_i};
			// Fill marker keeps reset zeros in the chain from posing as a strap
			bfill_q <= {bfill_q[1:0], 1'b1};
		end
	end

	// Strap is caught once after release, when the last two stages agree
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			boot_q <= BOOT_RST;
			boot_taken_q <= 1'b0;
		end else if (clk_en_i && !boot_taken_q && bfill_q[2] &&
			bsync_q[1] == bsync_q[2]) begin
			boot_q <= bsync_q[2];
			boot_taken_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			remap_q <= 1'b0;
		end else if (clk_en_i && remap_cmd_i) begin
			remap_q <= 1'b1;
		end
	end

	// ==========================================================
	// SRAM split and voltage range
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			isz_q <= 2'h0;
			dsz_q <= 2'h0;
		end else if (clk_en_i && tcm_cfg_wr_i) begin
			// Codes above two would overrun the 80 KB, so clamp them
			isz_q <= (instr_tight_sram_size_i > TCM_MAX) ? TCM_MAX : instr_tight_sram_size_i;
			dsz_q <= (data_tight_sram_size_i > TCM_MAX) ? TCM_MAX : data_tight_sram_size_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			vsel_q <= VSEL_3V3;
		end else if (clk_en_i && vsel_wr_i) begin
			vsel_q <= vsel_i;
		end
	end

	// ==========================================================
	// Address decode
	function automatic mxd_rsp_t dec_f(input logic [31:0] a, input logic cpu,
		input logic rmp, input logic bt, input logic [1:0] is,
		input logic [1:0] ds);
		mxd_rsp_t r;
		logic [3:0] bank;
		logic [7:0] rgn;
		logic [5:0] b;
		logic [5:0] csz;
		logic [3:0] fr;
		logic [5:0] n;
		r = '0;
		bank = a[BANK_HI:BANK_LO];
		rgn = a[RGN_HI:RGN_LO];
		b = a[BLK_HI:BLK_LO];
		csz = 6'(NUM_RB) - 6'(is) - 6'(ds);
		fr = {ds == 2'h0, ds != TCM_MAX, is == 2'h0, is != TCM_MAX};
		n = 6'h1;
		// SRAM C keeps its fixed block first, then free blocks downward
		if (cpu && rmp && rgn == RGN_BOOT)
			rgn = RGN_SRAMC;
		if (rgn == RGN_SRAMC && b == 6'h0)
			r.blk = RB4;
		for (int k = 3; k >= 0; k--) begin
			if (fr[k]) begin
				if (rgn == RGN_SRAMC && b == n)
					r.blk = 3'(k);
				n = n + 6'h1;
			end
		end
		if (bank >= BANK_EXT_FIRST && bank <= BANK_EXT_LAST) begin
			r.cs = bank - BANK_EXT_FIRST;
			r.slave = (r.cs < EXT0_CS_CNT) ? SL_EXT0 : SL_EXT1;
		end else if (bank == BANK_PERIPH) begin
			r.slave = SL_PERIPH;
		end else if (bank == BANK_INT) begin
			case (rgn)
				RGN_BOOT: begin
					if (bt && b < ROM_BLKS)
						r.slave = SL_ROM;
					else if (!bt)
						r.slave = SL_EXT0;
				end
				RGN_INSTR_TIGHT_SRAM: begin
					if (b < 6'(is)) begin
						r.slave = SL_INSTR_TIGHT_SRAM;
						r.blk = (b == 6'h0) ? RB1 : RB0;
					end
				end
				RGN_DATA_TIGHT_SRAM: begin
					if (b < 6'(ds)) begin
						r.slave = SL_DATA_TIGHT_SRAM;
						r.blk = (b == 6'h0) ? RB3 : RB2;
					end
				end
				RGN_SRAMC: begin
					if (b < csz)
						r.slave = SL_SRAMC;
				end
				RGN_ROM: begin
					if (b < ROM_BLKS)
						r.slave = SL_ROM;
				end
				RGN_SRAM16: begin
					if (b < SRAM16_BLKS)
						r.slave = SL_SRAM16;
				end
				default: r.slave = SL_NONE;
			endcase
		end
		if (r.slave != SL_EXT0 && r.slave != SL_EXT1)
			r.cs = 4'h0;
		if (!(r.slave inside {SL_INSTR_TIGHT_SRAM, SL_DATA_TIGHT_SRAM, SL_SRAMC}))
			r.blk = 3'h0;
		return r;
	endfunction

	// One decoder per master layer
	for (genvar m = 0; m < NUM_M; m++) begin : g_dec
		assign dec[m] = dec_f(req_i[m].addr, m == CPU_I || m == CPU_D,
			remap_q, boot_q, isz_q, dsz_q);
	end

	// ==========================================================
	// Per-slave arbitration
	for (genvar s = 0; s < NUM_S; s++) begin : g_slv
		logic [NUM_M-1:0] sreq;
		logic [3:0] own_q, own_d;
		logic vld_q, vld_d, hold, found;
		logic [7:0] slot_q;
		int k;
		always_comb begin
			k = 0;
			found = 1'b0;
			for (int m = 0; m < NUM_M; m++)
				sreq[m] = req_i[m].vld && dec[m].slave == mxd_slave_t'(4'(s + 1));
			// Owner keeps a burst until the slot limit meets a contender
			hold = vld_q && sreq[own_q] && !(arb_cfg_i.slot_lim != 8'h0 &&
				slot_q >= arb_cfg_i.slot_lim &&
				(sreq & ~(NUM_M'(1) << own_q)) != '0);
			own_d = own_q;
			vld_d = vld_q;
			if (!hold && sreq != '0) begin
				vld_d = 1'b1;
				if (arb_cfg_i.mode == ARB_FIXED) begin
					for (int i = NUM_M - 1; i >= 0; i--)
						if (sreq[i])
							own_d = 4'(i);
				end else begin
					for (int i = 1; i <= NUM_M; i++) begin
						k = (int'(own_q) + i) % NUM_M;
						if (!found && sreq[k]) begin
							own_d = 4'(k);
							found = 1'b1;
						end
					end
				end
			end else if (!hold) begin
				case (arb_cfg_i.mode)
					ARB_RR_NONE: vld_d = 1'b0;
					ARB_RR_FIXDEF: begin
						vld_d = arb_cfg_i.def_m < 4'(NUM_M);
						own_d = vld_d ? arb_cfg_i.def_m : own_q;
					end
					default: own_d = own_q;
				endcase
			end
			gs[s] = vld_d ? (sreq & (NUM_M'(1) << own_d)) : '0;
		end
		always_ff @(posedge clk_i) begin
			if (reset_i) begin
				own_q <= 4'h0;
				vld_q <= 1'b0;
				slot_q <= 8'h0;
			end else if (clk_en_i) begin
				own_q <= own_d;
				vld_q <= vld_d;
				if (hold)
					slot_q <= (slot_q == 8'hff) ? slot_q : slot_q + 8'h1;
				else
					slot_q <= (gs[s] != '0) ? 8'h1 : 8'h0;
			end
		end
		a_one_owner: assert property (@(posedge clk_i) disable iff (reset_i)
			$onehot0(gs[s])) else $error("slave granted twice");
	end

	// ==========================================================
	// Grants and responses
	always_comb begin
		gnt_o = '0;
		for (int s = 0; s < NUM_S; s++)
			gnt_o = gnt_o | gs[s];
	end

	for (genvar m = 0; m < NUM_M; m++) begin : g_rsp
		logic internal;
		assign internal = dec[m].slave inside {SL_ROM, SL_INSTR_TIGHT_SRAM, SL_DATA_TIGHT_SRAM,
			SL_SRAMC, SL_SRAM16};
		always_ff @(posedge clk_i) begin
			if (reset_i) begin
				rsp_q[m] <= '0;
			end else if (clk_en_i) begin
				rsp_q[m] <= req_i[m].vld ? dec[m] : '0;
				rsp_q[m].err <= req_i[m].vld && dec[m].slave == SL_NONE;
				rsp_q[m].done <= gnt_o[m] && (internal ||
					(dec[m].slave != SL_NONE &&
					slv_ready_i[3'(dec[m].slave - 4'h1)]));
			end
		end
	end

	assign rsp_o = rsp_q;
	assign remap_o = remap_q;
	assign boot_mode_o = boot_q;
	assign instr_tight_sram_size_o = isz_q;
	assign data_tight_sram_size_o = dsz_q;
	assign ext_if0_vsel_o = vsel_q;
	// Only instruction/data TCM blocks go to the core; RB4 stays on the bus
	assign rb_on_tcm_o = {1'b0, dsz_q != 2'h0, dsz_q == TCM_MAX,
		isz_q != 2'h0, isz_q == TCM_MAX};

	// ==========================================================
	// Checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i || !clk_en_i);

	a_bank_periph: assert property (req_i[2].vld &&
		req_i[2].addr[BANK_HI:BANK_LO] == BANK_PERIPH
		|=> rsp_o[2].slave == SL_PERIPH) else $error("periph bank");
	a_unused_abort: assert property (req_i[3].vld &&
		req_i[3].addr[BANK_HI:BANK_LO] inside {[4'ha:4'he]}
		|=> rsp_o[3].err && !rsp_o[3].done) else $error("no abort");
	a_ext_cs: assert property (req_i[4].vld &&
		req_i[4].addr[BANK_HI:BANK_LO] == 4'h7
		|=> rsp_o[4].slave == SL_EXT1 && rsp_o[4].cs == 4'h6)
		else $error("ext select");
	a_boot_rom: assert property (req_i[0].vld && !remap_q && boot_q &&
		req_i[0].addr == 32'h0 |=> rsp_o[0].slave == SL_ROM)
		else $error("boot rom");
	a_remap_sramc: assert property (req_i[1].vld && remap_q &&
		req_i[1].addr == 32'h0 |=> rsp_o[1].slave == SL_SRAMC &&
		rsp_o[1].blk == RB4) else $error("remap alias");
	a_remap_sticky: assert property (remap_q |=> remap_q)
		else $error("remap cleared");
	a_int_single: assert property (gnt_o[5] && dec[5].slave == SL_ROM
		|=> rsp_o[5].done) else $error("wait state");
	a_tcm_reset: assert property (@(posedge clk_i) disable iff (1'b0)
		reset_i |=> isz_q == 2'h0 && dsz_q == 2'h0 &&
		ext_if0_vsel_o == VSEL_3V3) else $error("reset split");
	a_split_sum: assert property ((isz_q + dsz_q) <= 3'h4 &&
		!rb_on_tcm_o[RB4]) else $error("bad split");
endmodule
`default_nettype wire

/* File: verification/mxd_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far-side slaves: ready at once, or stalling at random
module mxd_slave_model import mxd_pkg::*; (
	input wire logic clk_i,
	input wire logic stall_i,
	output logic [NUM_S-1:0] slv_ready_o
);
	initial slv_ready_o = '1;
	// Ready moves only after an edge, so a beat sees one value
	always @(posedge clk_i) begin
		slv_ready_o <= stall_i ? NUM_S'($urandom) : '1;
	end
endmodule
`default_nettype wire

/* File: verification/matrix_address_decode_remap_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module matrix_address_decode_remap_tb import mxd_pkg::*;;
	logic clk, rst, en, stall, bpin, rcmd, twr, vwr, vsel, rmp, bmode, vo;
	logic [1:0] isz, dsz, iso, dso;
	logic [4:0] rb;
	logic [NUM_S-1:0] rdy;
	logic [NUM_M-1:0] gnt;
	logic [31:0] a;
	mxd_cfg_t cfg;
	mxd_req_t [NUM_M-1:0] req;
	mxd_rsp_t [NUM_M-1:0] rsp;
	int mismatches, check_count, cyc, ib, db, x;
	bit mrmp, mboot;
	mxd_decode i_dut (.clk_i(clk), .reset_i(rst), .clk_en_i(en),
		.boot_select_pin_i(bpin), .remap_cmd_i(rcmd), .tcm_cfg_wr_i(twr),
		.instr_tight_sram_size_i(isz), .data_tight_sram_size_i(dsz), .vsel_wr_i(vwr), .vsel_i(vsel),
		.arb_cfg_i(cfg), .req_i(req), .slv_ready_i(rdy), .gnt_o(gnt),
		.rsp_o(rsp), .remap_o(rmp), .boot_mode_o(bmode), .instr_tight_sram_size_o(iso),
		.data_tight_sram_size_o(dso), .rb_on_tcm_o(rb), .ext_if0_vsel_o(vo));
	mxd_slave_model i_slv (.clk_i(clk), .stall_i(stall), .slv_ready_o(rdy));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ==========================================
	// Reference model of one decoder
	function automatic mxd_rsp_t model(int m, logic [31:0] ad);
		mxd_rsp_t r;
		int b, g, k, j;
		r = '0;
		b = int'(ad[31:28]);
		g = int'(ad[27:20]);
		k = int'(ad[19:14]);
		if (b >= 1 && b <= 9) begin
			r.slave = b <= 6 ? SL_EXT0 : SL_EXT1;
			r.cs = 4'(b - 1);
		end else if (b == 15) begin
			r.slave = SL_PERIPH;
		end else if (b == 0) begin
			case (g)
			0: r.slave = (m < 2 && mrmp) ? SL_SRAMC : mboot ? SL_ROM : SL_EXT0;
			1: if (k < ib) r.slave = SL_INSTR_TIGHT_SRAM;
			2: if (k < db) r.slave = SL_DATA_TIGHT_SRAM;
			3: if (k < 5 - ib - db) r.slave = SL_SRAMC;
			4: if (k < 8) r.slave = SL_ROM;
			5: if (k < 1) r.slave = SL_SRAM16;
			default: r.slave = SL_NONE;
			endcase
		end
		if (r.slave == SL_INSTR_TIGHT_SRAM)
			r.blk = k == 0 ? 3'h1 : 3'h0;
		if (r.slave == SL_DATA_TIGHT_SRAM)
			r.blk = k == 0 ? 3'h3 : 3'h2;
		if (r.slave == SL_SRAMC) begin
			// Fixed block first, then blocks left free by the TCMs, downward
			r.blk = 3'h4;
			j = 0;
			for (int q = 3; q >= 0; q--) begin
				if (!x[q])
					j++;
				if (!x[q] && j == k && k > 0)
					r.blk = 3'(q);
			end
		end
		r.err = r.slave == SL_NONE;
		r.done = !r.err && (r.slave < SL_EXT0 || rdy[r.slave - 1]);
		return r;
	endfunction
	// ==========================================
	// Comparison, beats and closing
	task automatic chk(logic [15:0] g, logic [15:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_rsp(int m, mxd_rsp_t e);
		if (e.err)
			chk(16'(rsp[m].err), 16'h1);
		else
			chk(16'({rsp[m].done, rsp[m].err, rsp[m].slave, rsp[m].cs,
				rsp[m].blk}), 16'({e.done, e.err, e.slave, e.cs,
				e.blk}));
	endtask
	task automatic beat(int m, logic [31:0] ad);
		mxd_rsp_t e;
		@(posedge clk);
		req[m] <= '{vld: 1'b1, addr: ad};
		@(negedge clk);
		e = model(m, ad);
		@(posedge clk);
		req[m].vld <= 1'b0;
		@(negedge clk);
		chk_rsp(m, e);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic do_reset(logic p);
		@(posedge clk);
		bpin <= p;
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		mrmp = 0;
		mboot = p;
		ib = 0;
		db = 0;
		x = 0;
		@(negedge clk);
		chk(16'({rmp, bmode, iso, dso, rb, vo}), 16'({1'b0, p, 10'h0}));
	endtask
	task automatic cfg_tcm(int i, int d);
		@(posedge clk);
		isz <= 2'(i);
		dsz <= 2'(d);
		twr <= 1'b1;
		@(posedge clk);
		twr <= 1'b0;
		@(negedge clk);
		ib = i > 2 ? 2 : i;
		db = d > 2 ? 2 : d;
		x = (ib > 0 ? 2 : 0) + (ib > 1 ? 1 : 0) + (db > 0 ? 8 : 0);
		x += db > 1 ? 4 : 0;
		chk(16'({iso, dso}), 16'(ib * 4 + db));
		chk(16'(rb), 16'(x));
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
	end
	// ==========================================
	// Scenarios
	initial begin
		{rst, stall, bpin, rcmd, twr, vwr, vsel, isz, dsz} = '0;
		cfg = '0;
		req = '0;
		rst = 1'b1;
		en = 1'b1;
		void'($urandom(32'h5d3a));
		do_reset(1'b0);
		beat(2, 32'h0);
		beat(0, 32'h0);
		@(posedge clk);
		en <= 1'b0;
		rcmd <= 1'b1;
		@(posedge clk);
		en <= 1'b1;
		@(negedge clk);
		chk(16'(rmp), 16'h0);
		@(posedge clk);
		rcmd <= 1'b0;
		mrmp = 1;
		@(negedge clk);
		chk(16'(rmp), 16'h1);
		for (int m = 0; m < 3; m++) beat(m, 32'h0);
		$display("test boot select and remap done");
		do_reset(1'b1);
		beat(1, 32'h0);
		@(posedge clk);
		vsel <= 1'b1;
		vwr <= 1'b1;
		@(posedge clk);
		vwr <= 1'b0;
		@(negedge clk);
		chk(16'(vo), 16'h1);
		$display("test voltage select done");
		for (int i = 0; i < 4; i++) for (int d = 0; d < 4; d++) begin
			cfg_tcm(i, d);
			stall <= 1'($urandom);
			cfg <= '{mxd_arb_t'($urandom_range(0, 3)), 4'h9, 8'h2};
			for (int n = 0; n < 20; n++) begin
				a = $urandom;
				if ($urandom_range(0, 1) == 1) a[31:28] = 4'h0;
				a[27:20] = a[31:28] == 0 ? 8'($urandom_range(0, 7)) : a[27:20];
				a[19:14] = 6'($urandom_range(0, 7));
				if (a[31:20] == 0) a[19:14] = 6'h0;
				beat($urandom_range(0, 8), a);
			end
		end
		$display("test sram split and random decode done");
		stall <= 1'b0;
		for (int md = 0; md < 4; md++) begin
			@(posedge clk);
			cfg <= '{mxd_arb_t'(md), 4'h3, 8'h0};
			req[3] <= '{1'b1, 32'h0040_0000};
			req[5] <= '{1'b1, 32'h0040_0000};
			req[7] <= '{1'b1, 32'hf000_0000};
			@(negedge clk);
			chk(16'($countones({gnt[3], gnt[5]})), 16'h1);
			chk(16'(gnt[7]), 16'h1);
			@(posedge clk);
			req <= '0;
			@(negedge clk);
			chk(16'($countones({rsp[3].done, rsp[5].done})), 16'h1);
			chk(16'({rsp[3].err, rsp[5].err, rsp[7].done}), 16'h1);
		end
		$display("test arbitration done");
		summarize();
	end
endmodule
`default_nettype wire
